// file: verilog/pmrc_top.sv
// Voltage regulator control register and idle/stop/suspend mode sequencer
//
// Functional notes
// - Bit 7 disables primary regulator when 1; read/write, resets to 0.
// - Bit 6 read-only, live bus-voltage level.
// - Bit 4 high puts primary regulator in low-power suspend mode.
// - Stop-shutdown bit 0 keeps core regulator active in stop mode.
// - Stop-shutdown 1 turns core regulator off; only pin reset wakes.
// - Bit 1 high puts core regulator in low-power mode.
// - Exactly three software modes: idle, stop and suspend.
// - Writing idle bit halts CPU after the writing instruction.
// - Idle keeps registers, memory and peripherals running.
// - Enabled interrupt ends idle, clears idle bit, resumes CPU.
// - Reset during idle ends it; restart at address zero.
// - Watchdog timeout reset terminates idle.
// - Stop halts CPU, internal oscillator, interrupts and timers except clock detector.
// - Suspend halts high-frequency oscillator, CPU runs elsewhere, USB wakes.
// - Writing stop bit enters stop after the writing instruction.
// - Stop ends only by internal or external reset.
// - Suspend bit halts high-frequency oscillator after the writing instruction.
// - Stop and idle bits always read as zero.
module pmrc_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register access from the core
  input wire pmrc_pkg::pmrc_sfr_req_type sfr_req,
  input wire logic instr_done,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  // Wake and reset sources
  input wire logic irq_pending,
  input wire logic usb_resume,
  input wire logic watchdog_reset,
  input wire logic clock_detector_reset,
  input wire logic pin_reset,
  // Bus voltage pin
  input wire logic vbus_pin,
  // Controls and status
  output pmrc_pkg::pmrc_ctrl_type ctrl,
  output logic core_reset_req,
  output logic [15:0] restart_vector,
  output logic [3:0] mode_state
);

  pmrc_pkg::pmrc_mode_type mode_r;
  pmrc_pkg::pmrc_mode_type mode_nxt;
  logic [7:0] vreg_r;
  logic [7:0] osc_r;
  logic [5:0] flags_r;
  logic idle_req_r;
  logic stop_req_r;
  logic susp_req_r;
  logic vbus_sync;
  logic wr_vreg;
  logic wr_power_control_register;
  logic wr_osc;
  logic int_reset;
  logic any_reset;

  // ============================================================
  // Bus voltage input, synchronised
  pmrc_sync #(
    .WIDTH(1)
  ) u_vbus_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(vbus_pin),
    .sync_out(vbus_sync)
  );

  // ============================================================
  // Address decode
  always_comb
  begin
    wr_vreg = 1'b0;
    wr_power_control_register = 1'b0;
    wr_osc = 1'b0;
    if (sfr_req.wr && sfr_req.addr == pmrc_pkg::REG_ADDR_VREG)
      wr_vreg = 1'b1;
    else if (sfr_req.wr && sfr_req.addr == pmrc_pkg::REG_ADDR_POWER_CONTROL_REGISTER)
      wr_power_control_register = 1'b1;
    else if (sfr_req.wr && sfr_req.addr == pmrc_pkg::REG_ADDR_OSC)
      wr_osc = 1'b1;
  end

  // Internal resets reach the core only while its regulator is powered
  always_comb
  begin
    int_reset = watchdog_reset || clock_detector_reset;
    // Timers are frozen in stop; only the clock detector can still fire
    if (mode_r == pmrc_pkg::MODE_STOP)
      int_reset = clock_detector_reset;
    if (mode_r == pmrc_pkg::MODE_STOP && vreg_r[pmrc_pkg::VREG_STOP_SHDN_BIT])
      int_reset = 1'b0;
    any_reset = pin_reset || int_reset;
  end

  // ============================================================
  // Voltage regulator control register
  // Reserved bits are dropped so they always read back as zero
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      vreg_r <= pmrc_pkg::VREG_RESET;
    else if (wr_vreg)
      vreg_r <= sfr_req.wdata & pmrc_pkg::VREG_WRITE_MASK;
  end

  // General purpose flags survive mode changes
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      flags_r <= pmrc_pkg::POWER_CONTROL_REGISTER_FLAG_RESET;
    else if (wr_power_control_register)
      flags_r <= sfr_req.wdata[pmrc_pkg::POWER_CONTROL_REGISTER_FLAG_LSB +: pmrc_pkg::POWER_CONTROL_REGISTER_FLAG_W];
  end

  // Suspend bit clears itself on wake; a reset also clears it
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      osc_r <= pmrc_pkg::OSC_RESET;
    else if (any_reset)
      osc_r <= pmrc_pkg::OSC_RESET;
    else if (wr_osc)
      osc_r <= sfr_req.wdata;
    else if (mode_r == pmrc_pkg::MODE_SUSPEND && usb_resume)
      osc_r[pmrc_pkg::OSC_SUSPEND_BIT] <= 1'b0;
  end

  // ============================================================
  // Mode requests held until the writing instruction completes
  // A write beside a completion is kept; only a reset in the same cycle drops the request
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      idle_req_r <= 1'b0;
    else if (any_reset)
      idle_req_r <= 1'b0;
    else if (wr_power_control_register && sfr_req.wdata[pmrc_pkg::POWER_CONTROL_REGISTER_IDLE_BIT])
      idle_req_r <= 1'b1;
    else if (instr_done)
      idle_req_r <= 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      stop_req_r <= 1'b0;
    else if (any_reset)
      stop_req_r <= 1'b0;
    else if (wr_power_control_register && sfr_req.wdata[pmrc_pkg::POWER_CONTROL_REGISTER_STOP_BIT])
      stop_req_r <= 1'b1;
    else if (instr_done)
      stop_req_r <= 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      susp_req_r <= 1'b0;
    else if (any_reset)
      susp_req_r <= 1'b0;
    else if (wr_osc && sfr_req.wdata[pmrc_pkg::OSC_SUSPEND_BIT])
      susp_req_r <= 1'b1;
    else if (instr_done)
      susp_req_r <= 1'b0;
  end

  // ============================================================
  // Mode sequencer
  always_comb
  begin
    mode_nxt = mode_r;
    case (mode_r)
      pmrc_pkg::MODE_RUN:
      begin
        if (instr_done && stop_req_r)
          mode_nxt = pmrc_pkg::MODE_STOP;
        else if (instr_done && idle_req_r)
          mode_nxt = pmrc_pkg::MODE_IDLE;
        else if (instr_done && susp_req_r)
          mode_nxt = pmrc_pkg::MODE_SUSPEND;
      end
      pmrc_pkg::MODE_IDLE:
      begin
        if (any_reset || irq_pending)
          mode_nxt = pmrc_pkg::MODE_RUN;
      end
      pmrc_pkg::MODE_STOP:
      begin
        if (any_reset)
          mode_nxt = pmrc_pkg::MODE_RUN;
      end
      pmrc_pkg::MODE_SUSPEND:
      begin
        if (any_reset || usb_resume)
          mode_nxt = pmrc_pkg::MODE_RUN;
      end
      default:
        mode_nxt = pmrc_pkg::MODE_RUN;
    endcase
    // Reset wins over every wake and every entry
    if (any_reset)
      mode_nxt = pmrc_pkg::MODE_RUN;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      mode_r <= pmrc_pkg::MODE_RUN;
    else
      mode_r <= mode_nxt;
  end

  // ============================================================
  // Register read port
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      sfr_rvalid <= 1'b0;
    else
      sfr_rvalid <= sfr_req.rd;
  end

  // Data drops to zero between reads so no stale value lingers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      sfr_rdata <= 8'h00;
    else
    begin
      if (!sfr_req.rd)
        sfr_rdata <= 8'h00;
      else if (sfr_req.addr == pmrc_pkg::REG_ADDR_VREG)
      begin
        // Bit 6 shows the synchronised pin, not a stored bit
        sfr_rdata <= vreg_r;
        sfr_rdata[pmrc_pkg::VREG_VBUS_BIT] <= vbus_sync;
      end
      else if (sfr_req.addr == pmrc_pkg::REG_ADDR_POWER_CONTROL_REGISTER)
        sfr_rdata <= {flags_r, 2'h0};
      else if (sfr_req.addr == pmrc_pkg::REG_ADDR_OSC)
        sfr_rdata <= osc_r;
      else
        sfr_rdata <= 8'h00;
    end
  end

  // ============================================================
  // Control outputs; idle stops only the CPU clock
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl <= '0;
    end
    else
    begin
      ctrl.pri_reg_disable <= vreg_r[pmrc_pkg::VREG_PRI_DIS_BIT];
      ctrl.pri_reg_low_power <= vreg_r[pmrc_pkg::VREG_PRI_LP_BIT];
      ctrl.core_reg_low_power <= vreg_r[pmrc_pkg::VREG_CORE_LP_BIT];
      ctrl.core_reg_shutdown <= (mode_nxt == pmrc_pkg::MODE_STOP) &&
        vreg_r[pmrc_pkg::VREG_STOP_SHDN_BIT];
      ctrl.cpu_halt <= (mode_nxt == pmrc_pkg::MODE_IDLE) ||
        (mode_nxt == pmrc_pkg::MODE_STOP);
      ctrl.int_osc_stop <= (mode_nxt == pmrc_pkg::MODE_STOP);
      ctrl.hf_osc_halt <= (mode_nxt == pmrc_pkg::MODE_STOP) ||
        (mode_nxt == pmrc_pkg::MODE_SUSPEND);
      ctrl.periph_clk_stop <= (mode_nxt == pmrc_pkg::MODE_STOP);
    end
  end

  // One cycle per accepted reset; the core restarts from the fixed vector
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      core_reset_req <= 1'b0;
    else
      core_reset_req <= any_reset;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      restart_vector <= pmrc_pkg::RESET_VECTOR;
    else
      restart_vector <= pmrc_pkg::RESET_VECTOR;
  end

  // Status follows the sequencer so it lines up with the controls
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      mode_state <= pmrc_pkg::MODE_RUN;
    else
      mode_state <= mode_nxt;
  end

endmodule

// file: verilog/pmrc_pkg.sv
// Package: register map, field positions, reset values and types for power mode control
package pmrc_pkg;

  // ============================================================
  // Special function register addresses
  localparam logic [7:0] REG_ADDR_VREG = 8'hC9;
  localparam logic [7:0] REG_ADDR_POWER_CONTROL_REGISTER = 8'h87;
  localparam logic [7:0] REG_ADDR_OSC = 8'hB2;

  // ============================================================
  // Voltage regulator control fields
  localparam int VREG_PRI_DIS_BIT = 7;
  localparam int VREG_VBUS_BIT = 6;
  localparam int VREG_PRI_LP_BIT = 4;
  localparam int VREG_STOP_SHDN_BIT = 3;
  localparam int VREG_CORE_LP_BIT = 1;
  localparam logic [7:0] VREG_WRITE_MASK = 8'h9A;
  localparam logic [7:0] VREG_RESET = 8'h00;

  // ============================================================
  // Power control fields
  localparam int POWER_CONTROL_REGISTER_IDLE_BIT = 0;
  localparam int POWER_CONTROL_REGISTER_STOP_BIT = 1;
  localparam int POWER_CONTROL_REGISTER_FLAG_LSB = 2;
  localparam int POWER_CONTROL_REGISTER_FLAG_W = 6;
  localparam logic [5:0] POWER_CONTROL_REGISTER_FLAG_RESET = 6'h00;

  // ============================================================
  // Oscillator control fields
  localparam int OSC_SUSPEND_BIT = 5;
  localparam logic [7:0] OSC_RESET = 8'h00;

  // ============================================================
  // Reset vector
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // ============================================================
  // Mode states, one-hot
  typedef enum logic [3:0] {
    MODE_RUN = 4'h1,
    MODE_IDLE = 4'h2,
    MODE_STOP = 4'h4,
    MODE_SUSPEND = 4'h8
  } pmrc_mode_type;

  // Special function register bus from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmrc_sfr_req_type;

  // Controls towards regulators and clock tree
  typedef struct packed {
    logic pri_reg_disable;
    logic pri_reg_low_power;
    logic core_reg_low_power;
    logic core_reg_shutdown;
    logic cpu_halt;
    logic int_osc_stop;
    logic hf_osc_halt;
    logic periph_clk_stop;
  } pmrc_ctrl_type;

endpackage

// file: verilog/pmrc_sync.sv
// Two-flop synchroniser for asynchronous level inputs
module pmrc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_r;

  // ============================================================
  // First stage feeds only the second
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stage1_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1_r <= async_in;
      sync_out <= stage1_r;
    end
  end

endmodule

// file: sim/pmrc_top_properties.sv
// Checker for register answers and power mode behaviour at the top ports
module pmrc_top_properties (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register access
  input wire pmrc_pkg::pmrc_sfr_req_type sfr_req,
  input wire logic instr_done,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rvalid,
  // Wake and reset sources
  input wire logic irq_pending,
  input wire logic usb_resume,
  input wire logic watchdog_reset,
  input wire logic clock_detector_reset,
  input wire logic pin_reset,
  input wire logic vbus_pin,
  // Controls and status
  input wire pmrc_pkg::pmrc_ctrl_type ctrl,
  input wire logic core_reset_req,
  input wire logic [15:0] restart_vector,
  input wire logic [3:0] mode_state
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic any_rst;
  assign any_rst = watchdog_reset | clock_detector_reset | pin_reset;
  // ==========
  // Assertions
  chk_power_control_register_low_zero: assert property (
    sfr_req.rd && sfr_req.addr == pmrc_pkg::REG_ADDR_POWER_CONTROL_REGISTER |=> sfr_rvalid && sfr_rdata[1:0] == 2'h0)
    else $error("power control low bits not zero");
  chk_vbus_live: assert property (
    $stable(vbus_pin)[*4] ##0 (sfr_req.rd && sfr_req.addr == pmrc_pkg::REG_ADDR_VREG)
    |=> sfr_rdata[6] == $past(vbus_pin))
    else $error("bus voltage bit wrong");
  chk_idle_halt: assert property (mode_state == pmrc_pkg::MODE_IDLE |->
    ctrl.cpu_halt && !ctrl.int_osc_stop && !ctrl.periph_clk_stop)
    else $error("idle controls wrong");
  chk_stop_halt: assert property (mode_state == pmrc_pkg::MODE_STOP |->
    ctrl.cpu_halt && ctrl.int_osc_stop) else $error("stop controls wrong");
  chk_susp_runs: assert property (mode_state == pmrc_pkg::MODE_SUSPEND |->
    !ctrl.cpu_halt && ctrl.hf_osc_halt) else $error("suspend controls wrong");
  chk_idle_wake: assert property (
    mode_state == pmrc_pkg::MODE_IDLE && irq_pending && !any_rst
    |=> mode_state == pmrc_pkg::MODE_RUN) else $error("idle did not wake");
  chk_stop_hold: assert property (
    mode_state == pmrc_pkg::MODE_STOP && !any_rst |=> mode_state == pmrc_pkg::MODE_STOP)
    else $error("stop left without reset");
  chk_shdn_ignore: assert property (
    mode_state == pmrc_pkg::MODE_STOP && ctrl.core_reg_shutdown && !pin_reset
    |=> mode_state == pmrc_pkg::MODE_STOP) else $error("shut down stop left");
  chk_pin_reset: assert property (pin_reset |=>
    core_reset_req && mode_state == pmrc_pkg::MODE_RUN && restart_vector == 16'h0000)
    else $error("pin reset not taken");
  cov_idle: cover property (mode_state == pmrc_pkg::MODE_IDLE);
  cov_stop: cover property (mode_state == pmrc_pkg::MODE_STOP && ctrl.core_reg_shutdown);
  cov_susp: cover property (mode_state == pmrc_pkg::MODE_SUSPEND);
endmodule

bind pmrc_top pmrc_top_properties u_chk (
  .ref_clk, .rst, .sfr_req, .instr_done, .sfr_rdata, .sfr_rvalid, .irq_pending,
  .usb_resume, .watchdog_reset, .clock_detector_reset, .pin_reset, .vbus_pin,
  .ctrl, .core_reset_req, .restart_vector, .mode_state
);

// file: sim/pmrc_top_test.sv
// Self-checking bench for register access and power modes
module pmrc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  pmrc_pkg::pmrc_sfr_req_type sfr_req = '0;
  // Events: done, irq, usb, watchdog, clock detector, pin
  logic [5:0] ev = 6'h00;
  logic vbus_pin = 1'b0;
  logic [7:0] sfr_rdata;
  logic sfr_rvalid;
  pmrc_pkg::pmrc_ctrl_type ctrl;
  logic core_reset_req;
  logic [15:0] restart_vector;
  logic [3:0] mode_state;
  int errors = 0;
  int checked = 0;
  int seed = 6;
  int pulses = 0;
  int vreg_m = 0;
  int flags_m = 0;
  int d;
  int i;

  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (core_reset_req === 1'b1) pulses++;

  pmrc_top u_pmrc_top (
    .ref_clk, .rst, .sfr_req, .instr_done(ev[0]), .sfr_rdata, .sfr_rvalid,
    .irq_pending(ev[1]), .usb_resume(ev[2]), .watchdog_reset(ev[3]),
    .clock_detector_reset(ev[4]), .pin_reset(ev[5]), .vbus_pin, .ctrl,
    .core_reset_req, .restart_vector, .mode_state
  );

  // ==========
  // Tasks
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s exp %h seen %h", n, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Model follows writes to the regulator and power control registers, not the oscillator register
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    if (a == 8'hC9)
      vreg_m = v & 8'h9A;
    if (a == 8'h87)
      flags_m = v & 8'hFC;
    @(posedge ref_clk);
    sfr_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string n);
    @(posedge ref_clk);
    sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    sfr_req <= '0;
    @(negedge ref_clk);
    check(n, {sfr_rvalid, sfr_rdata}, {1'b1, exp});
  endtask

  // Ends at a falling edge so the effect of the event has landed
  task automatic pulse(input int k);
    @(posedge ref_clk);
    ev <= 6'h01 << k;
    @(posedge ref_clk);
    ev <= 6'h00;
    @(negedge ref_clk);
  endtask

  task automatic mode_is(input logic [3:0] m);
    int n;
    for (n = 0; n < 8 && mode_state !== m; n++)
      @(negedge ref_clk);
    check("mode", mode_state, m);
    if (n == 8)
      test_done();
  endtask

  // ==========
  // Main sequence
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    mode_is(4'h1);
    check("ctrl", ctrl, 8'h00);
    rd(8'hC9, 8'h00, "vreg");
    rd(8'h55, 8'h00, "unmapped");
    $display("reset test done");
    for (i = 0; i < 6; i++)
    begin
      d = $random(seed);
      @(posedge ref_clk);
      vbus_pin <= d[8];
      wr(8'hC9, d[7] ? d[7:0] & 8'hFD : d[7:0]);
      wr(8'h87, d[15:8] & 8'hFC);
      repeat (3) @(posedge ref_clk);
      rd(8'hC9, vreg_m | (d[8] << 6), "vreg");
      rd(8'h87, flags_m, "power_control_register");
      check("ctrl", ctrl[7:5], {vreg_m[7], vreg_m[4], vreg_m[1]});
    end
    $display("register test done");
    wr(8'hC9, 8'h00);
    wr(8'h87, 8'h05);
    pulse(0);
    mode_is(4'h2);
    check("idle", {ctrl.cpu_halt, ctrl.int_osc_stop, ctrl.periph_clk_stop}, 3'h4);
    rd(8'h87, flags_m, "power_control_register");
    pulse(1);
    mode_is(4'h1);
    rd(8'h87, flags_m, "power_control_register");
    wr(8'h87, 8'h01);
    pulse(0);
    mode_is(4'h2);
    d = pulses;
    pulse(3);
    mode_is(4'h1);
    @(negedge ref_clk);
    check("rstreq", pulses - d, 16'h0001);
    $display("idle test done");
    wr(8'h87, 8'h03);
    pulse(0);
    mode_is(4'h4);
    check("stop", {ctrl.cpu_halt, ctrl.int_osc_stop, ctrl.core_reg_shutdown}, 3'h6);
    pulse(1);
    mode_is(4'h4);
    pulse(3);
    mode_is(4'h4);
    pulse(4);
    mode_is(4'h1);
    wr(8'hC9, 8'h08);
    wr(8'h87, 8'h02);
    pulse(0);
    mode_is(4'h4);
    check("shdn", ctrl.core_reg_shutdown, 1'b1);
    pulse(3);
    pulse(4);
    mode_is(4'h4);
    pulse(5);
    mode_is(4'h1);
    $display("stop test done");
    wr(8'hB2, 8'h20);
    pulse(0);
    mode_is(4'h8);
    check("susp", {ctrl.cpu_halt, ctrl.hf_osc_halt}, 2'h1);
    rd(8'hB2, 8'h20, "osc");
    pulse(2);
    mode_is(4'h1);
    rd(8'hB2, 8'h00, "osc");
    $display("suspend test done");
    test_done();
  end
endmodule
